// ===== hdl/dlc_defines.svh
// Constants for the converter load control block.
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH
`define DLC_DATA_W 12
`define DLC_CODE_RESET 12'h000
`define DLC_SEL_RESET 3'h0
`define DLC_SEL_RISE 3'h0
`define DLC_SEL_SOFT 3'h1
`define DLC_SEL_RSVD 3'h2
`define DLC_SEL_SOFT_ALIAS 3'h3
`define DLC_SEL_FALL 3'h4
`define DLC_SEL_SQUARE 3'h5
`define DLC_SEL_RISE_ALIAS0 3'h6
`define DLC_SEL_RISE_ALIAS1 3'h7
`define DLC_FULL_SCALE 13'h1000
`endif

// ===== hdl/dlc_edge_if.sv
// Interface carrying synchronised strobe edges between modules.
`timescale 1ns/1ns
`default_nettype none
interface dlc_edge_if;
    logic rise;
    logic fall;
    modport source (output rise, output fall);
    modport sink (input rise, input fall);
endinterface : dlc_edge_if
`default_nettype wire

// ===== hdl/dlc_load_ctrl.sv
// Double-buffered load control for a 12-bit voltage-output converter.
`timescale 1ns/1ns
`default_nettype none
`include "dlc_defines.svh"
module dlc_load_ctrl #(
    parameter int DATA_W = `DLC_DATA_W
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] load_select_in,
    input wire logic conv_power_enable_in,
    input wire logic staging_wr_in,
    input wire logic [DATA_W-1:0] staging_data_in,
    input wire logic ext_load_strobe_in,
    output logic [DATA_W-1:0] conv_staging_reg_out,
    output logic [DATA_W-1:0] conv_output_reg_out,
    output logic [DATA_W-1:0] dac_code_out,
    output logic dac_power_out,
    output logic shared_pin_alt_out,
    output logic shared_pin_pullup_out,
    output logic conv_load_out
);
    // ------------------------------------------------------------
    // Strobe synchronisation
    // ------------------------------------------------------------
    dlc_edge_if edges ();

    dlc_strobe_sync u_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .strobe_in(ext_load_strobe_in),
        .edge_out(edges)
    );

    // ------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------
    dlc_pkg::dlc_mode_t mode;

    always_comb begin
        case (load_select_in)
            `DLC_SEL_RISE: mode = dlc_pkg::DLC_MODE_RISE;
            `DLC_SEL_RISE_ALIAS0: mode = dlc_pkg::DLC_MODE_RISE;
            `DLC_SEL_RISE_ALIAS1: mode = dlc_pkg::DLC_MODE_RISE;
            `DLC_SEL_SOFT: mode = dlc_pkg::DLC_MODE_SOFT;
            `DLC_SEL_SOFT_ALIAS: mode = dlc_pkg::DLC_MODE_SOFT;
            `DLC_SEL_RSVD: mode = dlc_pkg::DLC_MODE_IDLE;
            `DLC_SEL_FALL: mode = dlc_pkg::DLC_MODE_FALL;
            `DLC_SEL_SQUARE: mode = dlc_pkg::DLC_MODE_SQUARE;
            default: mode = dlc_pkg::DLC_MODE_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Register transfers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_staging;
    logic [DATA_W-1:0] next_output;
    dlc_pkg::dlc_src_t src;
    dlc_pkg::dlc_src_t next_src;
    logic next_load;
    logic next_alt;
    logic next_power;
    logic [DATA_W-1:0] next_code;

    always_comb begin
        next_staging = conv_staging_reg_out;
        next_output = conv_output_reg_out;
        next_src = src;
        next_load = 1'b0;
        if (staging_wr_in) begin
            next_staging = staging_data_in;
        end
        case (mode)
            dlc_pkg::DLC_MODE_SOFT: begin
                next_src = dlc_pkg::DLC_SRC_OUTPUT;
                if (staging_wr_in) begin
                    next_output = staging_data_in;
                    next_load = 1'b1;
                end
            end
            dlc_pkg::DLC_MODE_RISE: begin
                next_src = dlc_pkg::DLC_SRC_OUTPUT;
                if (edges.rise) begin
                    next_output = conv_staging_reg_out;
                    next_load = 1'b1;
                end
            end
            dlc_pkg::DLC_MODE_FALL: begin
                next_src = dlc_pkg::DLC_SRC_OUTPUT;
                if (edges.fall) begin
                    next_output = conv_staging_reg_out;
                    next_load = 1'b1;
                end
            end
            dlc_pkg::DLC_MODE_SQUARE: begin
                if (edges.fall) begin
                    next_src = dlc_pkg::DLC_SRC_STAGING;
                    next_load = 1'b1;
                end else if (edges.rise) begin
                    next_src = dlc_pkg::DLC_SRC_OUTPUT;
                    next_load = 1'b1;
                end
            end
            default: begin
                next_src = dlc_pkg::DLC_SRC_OUTPUT;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Converter drive
    // ------------------------------------------------------------
    always_comb begin
        if (next_src == dlc_pkg::DLC_SRC_STAGING) begin
            next_code = next_staging;
        end else begin
            next_code = next_output;
        end
        next_power = conv_power_enable_in;
        next_alt = (mode == dlc_pkg::DLC_MODE_RISE) ||
                   (mode == dlc_pkg::DLC_MODE_FALL) ||
                   (mode == dlc_pkg::DLC_MODE_SQUARE);
    end

    // reset leaves pin as pulled-up port I/O
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv_staging_reg_out <= `DLC_CODE_RESET;
            conv_output_reg_out <= `DLC_CODE_RESET;
            dac_code_out <= `DLC_CODE_RESET;
            src <= dlc_pkg::DLC_SRC_OUTPUT;
            dac_power_out <= 1'b0;
            shared_pin_alt_out <= 1'b0;
            shared_pin_pullup_out <= 1'b1;
            conv_load_out <= 1'b0;
        end else begin
            conv_staging_reg_out <= next_staging;
            conv_output_reg_out <= next_output;
            dac_code_out <= next_code;
            src <= next_src;
            dac_power_out <= next_power;
            shared_pin_alt_out <= next_alt;
            shared_pin_pullup_out <= ~next_alt;
            conv_load_out <= next_load & conv_power_enable_in;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // straight binary word reaches the core
    AST_CODE_SOURCE: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        dac_code_out == ((src == dlc_pkg::DLC_SRC_STAGING) ?
            conv_staging_reg_out : conv_output_reg_out))
        else $error("Converter code differs from the selected register.");
    AST_SOFT_LOAD: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (staging_wr_in && (load_select_in == `DLC_SEL_SOFT ||
            load_select_in == `DLC_SEL_SOFT_ALIAS))
        |=> conv_output_reg_out == $past(staging_data_in))
        else $error("Software write did not load output register.");
    AST_RISE_LOAD: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (edges.rise && (load_select_in == `DLC_SEL_RISE ||
            load_select_in == `DLC_SEL_RISE_ALIAS0 ||
            load_select_in == `DLC_SEL_RISE_ALIAS1))
        |=> conv_output_reg_out == $past(conv_staging_reg_out))
        else $error("Rising edge did not copy staging.");
    AST_FALL_LOAD: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (edges.fall && load_select_in == `DLC_SEL_FALL)
        |=> conv_output_reg_out == $past(conv_staging_reg_out))
        else $error("Falling edge did not copy staging.");
    AST_SQUARE_NOCOPY: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (load_select_in == `DLC_SEL_SQUARE)
        |=> $stable(conv_output_reg_out))
        else $error("Square-wave mode changed the output register.");
    AST_SQUARE_FALL: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (load_select_in == `DLC_SEL_SQUARE && edges.fall && !staging_wr_in)
        |=> dac_code_out == conv_staging_reg_out)
        else $error("Falling edge in square mode did not show staging.");
    AST_RSVD_IDLE: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (load_select_in == `DLC_SEL_RSVD) |=> $stable(conv_output_reg_out))
        else $error("Reserved selector changed the output register.");
    AST_POWER_GATE: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !$past(conv_power_enable_in) |-> !conv_load_out)
        else $error("Conversion started while powered down.");
    AST_PIN_ALT: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (load_select_in == `DLC_SEL_FALL) |=> shared_pin_alt_out
            && !shared_pin_pullup_out)
        else $error("Strobe mode did not claim the shared pin.");
    AST_OFF_WRITE: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (staging_wr_in && !conv_power_enable_in)
        |=> conv_staging_reg_out == $past(staging_data_in))
        else $error("Staging write lost while powered down.");
    COV_SOFT: cover property (@(posedge core_clk_in)
        load_select_in == `DLC_SEL_SOFT && staging_wr_in &&
        conv_power_enable_in);
    COV_SQUARE: cover property (@(posedge core_clk_in)
        load_select_in == `DLC_SEL_SQUARE && edges.rise);
    COV_FALL: cover property (@(posedge core_clk_in)
        load_select_in == `DLC_SEL_FALL && edges.fall);
endmodule : dlc_load_ctrl
`default_nettype wire

// ===== hdl/dlc_pkg.sv
// Types shared by the converter load control modules.
package dlc_pkg;
    typedef enum logic [2:0] {
        DLC_MODE_RISE = 3'b000,
        DLC_MODE_SOFT = 3'b001,
        DLC_MODE_IDLE = 3'b010,
        DLC_MODE_FALL = 3'b100,
        DLC_MODE_SQUARE = 3'b101
    } dlc_mode_t;
    typedef enum logic [0:0] {
        DLC_SRC_OUTPUT = 1'b0,
        DLC_SRC_STAGING = 1'b1
    } dlc_src_t;
endpackage : dlc_pkg

// ===== hdl/dlc_strobe_sync.sv
// Two-stage synchroniser and edge detector for the load strobe.
`timescale 1ns/1ns
`default_nettype none
module dlc_strobe_sync (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic strobe_in,
    dlc_edge_if.source edge_out
);
    logic meta;
    logic sync;
    logic last;
    logic next_meta;
    logic next_sync;
    logic next_last;

    always_comb begin
        next_meta = strobe_in;
        next_sync = meta;
        next_last = sync;
    end

    // Reset high matches the pin's pull-up, so no false edge at release.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    assign edge_out.rise = sync & ~last;
    assign edge_out.fall = ~sync & last;

    AST_EDGE_EXCL: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !(edge_out.rise && edge_out.fall))
        else $error("Both strobe edges flagged in one cycle.");
    AST_RISE_LATENCY: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_out.rise |-> $past(strobe_in, 2) && !$past(strobe_in, 3))
        else $error("Rising edge not two cycles after the pin rose.");
endmodule : dlc_strobe_sync
`default_nettype wire

// ===== tb/dlc_strobe_src.sv
// Behavioural source that drives the external load strobe pin.
`timescale 1ns/1ns
`default_nettype none
module dlc_strobe_src (
    input wire logic core_clk_in,
    input wire logic pin_is_input_in,
    output logic strobe_out
);
    // The pin idles high because the shared pin carries a pull-up.
    initial strobe_out = 1'b1;

    // strobe level hold
    // Each level is held for a caller-chosen number of cycles.
    // A short hold gives a prompt source; a long one gives a slow source.
    task automatic drive(input logic lvl, input int hold);
        @(posedge core_clk_in);
        if (pin_is_input_in) begin
            strobe_out <= lvl;
        end
        repeat (hold) @(posedge core_clk_in);
    endtask : drive
endmodule : dlc_strobe_src
`default_nettype wire

// ===== tb/tb_dac_load_control.sv
// Self-checking bench for the converter load control block.
`timescale 1ns/1ns
`default_nettype none
module tb_dac_load_control;
    logic core_clk_in;
    logic rstn_in;
    logic [2:0] load_sel;
    logic power_en;
    logic staging_wr;
    logic [11:0] staging_data;
    logic strobe;
    logic [11:0] staging_q;
    logic [11:0] output_q;
    logic [11:0] code_q;
    logic dac_power;
    logic pin_alt;
    logic pin_pullup;
    logic conv_load;
    logic [2:0] rise_sels [3] = '{3'h0, 3'h6, 3'h7};
    logic [11:0] rise_data [3] = '{12'h7ff, 12'h001, 12'h800};
    logic [11:0] rise_prev [3] = '{12'h123, 12'h7ff, 12'h001};
    // Slow strobe hold and power-up wait in 8 ns cycles: 15 us and 16 us.
    localparam int FAST_HOLD = 8;
    localparam int SETTLE_CYCLES = 1875;
    localparam int POWER_UP_CYCLES = 2000;
    int mismatches = 0;
    int samples_checked = 0;
    int loads = 0;
    int hold_cycles;
    logic pin_input;

    dlc_load_ctrl DUT (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .load_select_in(load_sel),
        .conv_power_enable_in(power_en),
        .staging_wr_in(staging_wr),
        .staging_data_in(staging_data),
        .ext_load_strobe_in(strobe),
        .conv_staging_reg_out(staging_q),
        .conv_output_reg_out(output_q),
        .dac_code_out(code_q),
        .dac_power_out(dac_power),
        .shared_pin_alt_out(pin_alt),
        .shared_pin_pullup_out(pin_pullup),
        .conv_load_out(conv_load)
    );

    dlc_strobe_src u_src (
        .core_clk_in(core_clk_in),
        .pin_is_input_in(pin_input),
        .strobe_out(strobe)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        if (conv_load === 1'b1) begin
            loads++;
        end
    end

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cfg(input logic [2:0] sel, input logic pwr);
        @(posedge core_clk_in);
        load_sel <= sel;
        power_en <= pwr;
        repeat (3) @(posedge core_clk_in);
        #1;
    endtask : cfg

    task automatic wr(input logic [11:0] d, input logic [11:0] exp_out,
                      input logic exp_load);
        @(posedge core_clk_in);
        staging_wr <= 1'b1;
        staging_data <= d;
        @(posedge core_clk_in);
        staging_wr <= 1'b0;
        #1;
        chk(staging_q, d);
        chk(output_q, exp_out);
        chk({11'h000, conv_load}, {11'h000, exp_load});
    endtask : wr

    // The wait covers synchroniser delay plus the registered update.
    task automatic edge_to(input logic lvl, input int exp_n);
        @(posedge core_clk_in);
        #1;
        loads = 0;
        u_src.drive(lvl, hold_cycles);
        #1;
        chk(loads[11:0], exp_n[11:0]);
    endtask : edge_to

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #100000;
        mismatches++;
        final_report();
    end

    initial begin
        rstn_in = 1'b0;
        load_sel = 3'h1;
        power_en = 1'b0;
        staging_wr = 1'b0;
        staging_data = 12'h000;
        pin_input = 1'b0;
        hold_cycles = FAST_HOLD;
        repeat (4) @(posedge core_clk_in);
        #1;
        chk({11'h000, pin_pullup}, 12'h001);
        chk({11'h000, pin_alt}, 12'h000);
        chk(code_q, 12'h000);
        @(posedge core_clk_in);
        rstn_in <= 1'b1;
        cfg(3'h1, 1'b1);
        chk({11'h000, dac_power}, 12'h001);
        wr(12'habc, 12'habc, 1'b1);
        chk(code_q, 12'habc);
        cfg(3'h3, 1'b1);
        wr(12'h123, 12'h123, 1'b1);
        cfg(3'h2, 1'b1);
        wr(12'h456, 12'h123, 1'b0);
        chk({11'h000, pin_alt}, 12'h000);
        pin_input = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cfg(rise_sels[i], 1'b1);
            chk({11'h000, pin_alt}, 12'h001);
            chk({11'h000, pin_pullup}, 12'h000);
            wr(rise_data[i], rise_prev[i], 1'b0);
            edge_to(1'b0, 0);
            edge_to(1'b1, 1);
            chk(output_q, rise_data[i]);
            chk(code_q, rise_data[i]);
        end
        cfg(3'h4, 1'b1);
        wr(12'h2aa, 12'h800, 1'b0);
        edge_to(1'b0, 1);
        chk(output_q, 12'h2aa);
        edge_to(1'b1, 0);
        wr(12'h800, 12'h2aa, 1'b0);
        cfg(3'h5, 1'b1);
        hold_cycles = SETTLE_CYCLES;
        edge_to(1'b0, 1);
        chk(code_q, 12'h800);
        chk(output_q, 12'h2aa);
        edge_to(1'b1, 1);
        chk(code_q, 12'h2aa);
        hold_cycles = FAST_HOLD;
        cfg(3'h1, 1'b0);
        chk({11'h000, dac_power}, 12'h000);
        wr(12'hfff, 12'hfff, 1'b0);
        cfg(3'h0, 1'b0);
        wr(12'h055, 12'hfff, 1'b0);
        edge_to(1'b0, 0);
        edge_to(1'b1, 0);
        chk(output_q, 12'h055);
        cfg(3'h0, 1'b1);
        repeat (POWER_UP_CYCLES) @(posedge core_clk_in);
        #1;
        chk({11'h000, dac_power}, 12'h001);
        chk(code_q, 12'h055);
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        chk({11'h000, pin_pullup}, 12'h001);
        chk({11'h000, pin_alt}, 12'h000);
        chk(output_q, 12'h000);
        @(posedge core_clk_in);
        rstn_in <= 1'b1;
        cfg(3'h0, 1'b1);
        chk({11'h000, pin_alt}, 12'h001);
        final_report();
    end
endmodule : tb_dac_load_control
`default_nettype wire
